//--- include/tmh_pkg.sv
package tmh_pkg;

  // ************************************************************
  // register map: word indexes, byte address is four times the index (odd offsets cannot be aligned words)
  // ************************************************************
  localparam logic [15:0] TMH_ADDR_PERIOD = 16'hff0e;
  localparam logic [15:0] TMH_ADDR_DUTY = 16'hff0f;
  localparam logic [15:0] TMH_ADDR_MODE = 16'hff70;
  localparam logic [15:0] TMH_ADDR_IRQ_STATUS = 16'hff80;
  localparam logic [15:0] TMH_ADDR_IRQ_MASK = 16'hff84;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int TMH_BIT_RUN = 7;
  localparam int TMH_BIT_CKS_HI = 6;
  localparam int TMH_BIT_CKS_LO = 4;
  localparam int TMH_BIT_MODE_HI = 3;
  localparam int TMH_BIT_MODE_LO = 2;
  localparam int TMH_BIT_LEVEL = 1;
  localparam int TMH_BIT_GATE = 0;
  localparam logic [7:0] TMH_RST_REG8 = 8'h00;

  // ************************************************************
  // clock select and mode codes
  // ************************************************************
  localparam logic [2:0] TMH_CKS_DIV1 = 3'h0;
  localparam logic [2:0] TMH_CKS_DIV4 = 3'h1;
  localparam logic [2:0] TMH_CKS_DIV16 = 3'h2;
  localparam logic [2:0] TMH_CKS_DIV64 = 3'h3;
  localparam logic [2:0] TMH_CKS_DIV4096 = 3'h4;
  localparam logic [2:0] TMH_CKS_LSOSC128 = 3'h5;
  localparam int TMH_PRE_W = 12;
  localparam int TMH_LS_DIV_W = 7;

  typedef enum logic [1:0]
  {
    TMH_MODE_INTERVAL = 2'b00,
    TMH_MODE_PWM = 2'b10
  } tmh_mode_t;

  typedef struct packed
  {
    logic run_enable;
    logic [2:0] clk_sel;
    logic [1:0] op_mode_sel;
    logic out_default_level;
    logic out_gate;
  } tmh_mode_control_t;

endpackage

//--- sim/tmh_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
module tmh_timer_props
  import tmh_pkg::*;
(
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // timer
  input wire logic timer_out_pin,
  input wire logic match_irq,
  input wire logic irq
);
  // ****
  // shadow of the registers, rebuilt from bus traffic
  // ****
  logic ph_w, ph_r, mask_q, armed;
  logic [15:0] ph_a;
  logic [7:0] mode_q, per_q;
  logic [2:0] sm;
  int gap;
  wire mw = ph_w && (ph_a == TMH_ADDR_MODE);
  function automatic int span(logic [2:0] c, logic [7:0] p);
    return (c == 3'h4 ? 4096 : (1 << (2 * c))) * (p + 1) - 1;
  endfunction
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ph_w <= 1'b0;
      ph_r <= 1'b0;
      ph_a <= 16'h0;
      gap <= 0;
      armed <= 1'b0;
      sm <= 3'h0;
      mode_q <= 8'h00;
      per_q <= 8'h00;
      mask_q <= 1'b0;
    end
    else
    begin
      ph_w <= hsel && hready && htrans[1] && hwrite;
      ph_r <= hsel && hready && htrans[1] && !hwrite;
      ph_a <= haddr[17:2];
      gap <= match_irq ? 0 : gap + 1;
      // first gap after a start is partial, so only count once a match was seen
      armed <= mw ? 1'b0 : (armed || match_irq);
      sm <= mw ? 3'h0 : (sm == 3'h7 ? sm : sm + 3'h1);
      if (mw) mode_q <= hwdata[7:0];
      if (ph_w && ph_a == TMH_ADDR_PERIOD) per_q <= hwdata[7:0];
      if (ph_w && ph_a == TMH_ADDR_IRQ_MASK) mask_q <= hwdata[0];
    end
  // ****
  // assertions
  // ****
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_high_a: assert property (hreadyout) else $error("hreadyout low");
  resp_okay_a: assert property (!hresp) else $error("error response");
  read_upper_a: assert property (ph_r |-> hrdata[31:8] == 24'h0) else $error("upper read bits set");
  match_gap_a: assert property (match_irq && armed && mode_q[7] && mode_q[6:4] < 3'h5
    |-> gap == span(mode_q[6:4], per_q)) else $error("match spacing wrong");
  match_pulse_a: assert property (match_irq && per_q != 8'h00 |=> !match_irq) else $error("match not a pulse");
  irq_masked_a: assert property (!mask_q && !$past(mask_q) |-> !irq) else $error("masked irq high");
  gate_off_a: assert property (sm == 3'h7 && !mode_q[0] |-> timer_out_pin == mode_q[1])
    else $error("gated pin not default");
  stop_quiet_a: assert property (sm == 3'h7 && !mode_q[7] |-> timer_out_pin == mode_q[1] && !match_irq)
    else $error("stopped timer active");
  cover property (match_irq && mode_q[3:2] == 2'b10);
  cover property ($rose(irq));
  cover property (ph_r && ph_a == TMH_ADDR_MODE);
endmodule // tmh_timer_props
bind tmh_timer tmh_timer_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .timer_out_pin(timer_out_pin), .match_irq(match_irq), .irq(irq));
`default_nettype wire

//--- sim/tmh_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module tmh_timer_test;
  import tmh_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ls_osc_tick = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0, lsd = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, timer_out_pin, match_irq, irq;
  wire hready = hreadyout;
  int failures = 0, tests_run = 0, n;
  int div[6] = '{1, 4, 16, 64, 4096, 384};
  tmh_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ls_osc_tick(ls_osc_tick), .timer_out_pin(timer_out_pin), .match_irq(match_irq), .irq(irq));
  always #2 hclk = ~hclk;
  // oscillator tick every third cycle
  always @(posedge hclk)
  begin
    lsd <= (lsd == 2'h2) ? 2'h0 : lsd + 2'h1;
    ls_osc_tick <= (lsd == 2'h2);
  end
  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {14'h0, a, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // pin: width of next high pulse; else cycles between two match pulses
  task automatic meas(input bit pin);
    n = 0;
    if (pin) do @(posedge hclk); while (timer_out_pin !== 1'b0);
    do @(posedge hclk); while ((pin ? timer_out_pin : match_irq) !== 1'b1);
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (((pin ? timer_out_pin : match_irq) === 1'b1) == pin);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs();
    logic [15:0] a[3] = '{TMH_ADDR_PERIOD, TMH_ADDR_DUTY, TMH_ADDR_MODE};
    for (int i = 0; i < 3; i++)
    begin
      bus(a[i], 1'b0, 8'h00);
      chk(r, 32'h0);
      bus(a[i], 1'b1, 8'(8'h28 + i));
      bus(a[i], 1'b0, 8'h00);
      chk(r, 32'h28 + i);
    end
    bus(16'hff10, 1'b1, 8'hff);
    bus(16'hff10, 1'b0, 8'h00);
    chk(r, 32'h0);
    $display("registers done");
  endtask
  task automatic t_interval();
    bus(TMH_ADDR_PERIOD, 1'b1, 8'h04);
    bus(TMH_ADDR_MODE, 1'b1, 8'h81);
    meas(1'b0);
    chk(n, 5);
    meas(1'b1);
    chk(n, 5);
    bus(TMH_ADDR_MODE, 1'b1, 8'h01);
    repeat (8) @(posedge hclk);
    chk({timer_out_pin, match_irq}, 0);
    bus(TMH_ADDR_MODE, 1'b1, 8'h03);
    repeat (8) @(posedge hclk);
    chk(timer_out_pin, 1);
    $display("interval done");
  endtask
  task automatic t_clksel();
    bus(TMH_ADDR_PERIOD, 1'b1, 8'h00);
    for (int c = 0; c < 7; c++)
    begin
      bus(TMH_ADDR_MODE, 1'b1, {1'b1, 3'(c), 4'h0});
      if (c < 6)
      begin
        meas(1'b0);
        meas(1'b0);
        chk(n, div[c]);
      end
      else
      begin
        // prohibited code: no count ticks, so waiting for a match would hang
        repeat (64) @(posedge hclk);
        chk(match_irq, 0);
      end
      bus(TMH_ADDR_MODE, 1'b1, {1'b0, 3'(c), 4'h0});
    end
    $display("clock select done");
  endtask
  task automatic t_pwm();
    bus(TMH_ADDR_PERIOD, 1'b1, 8'h09);
    bus(TMH_ADDR_DUTY, 1'b1, 8'h03);
    bus(TMH_ADDR_MODE, 1'b1, 8'h89);
    meas(1'b0);
    chk(n, 10);
    meas(1'b1);
    chk(n, 4);
    bus(TMH_ADDR_DUTY, 1'b1, 8'h05);
    meas(1'b0);
    meas(1'b0);
    meas(1'b1);
    chk(n, 6);
    // meas returns two edges after a duty match; period is 10, so this write lands on the next duty match
    repeat (5) @(posedge hclk);
    bus(TMH_ADDR_DUTY, 1'b1, 8'h02);
    meas(1'b1);
    chk(n, 6);
    meas(1'b1);
    chk(n, 3);
    bus(TMH_ADDR_MODE, 1'b1, 8'h09);
    $display("pwm done");
  endtask
  task automatic t_irq();
    bus(TMH_ADDR_IRQ_MASK, 1'b1, 8'h01);
    bus(TMH_ADDR_PERIOD, 1'b1, 8'h02);
    bus(TMH_ADDR_MODE, 1'b1, 8'h80);
    meas(1'b0);
    bus(TMH_ADDR_MODE, 1'b1, 8'h00);
    bus(TMH_ADDR_IRQ_STATUS, 1'b0, 8'h00);
    chk(r, 32'h1);
    chk(irq, 1);
    bus(TMH_ADDR_IRQ_MASK, 1'b1, 8'h00);
    repeat (3) @(posedge hclk);
    chk(irq, 0);
    bus(TMH_ADDR_IRQ_MASK, 1'b1, 8'h01);
    bus(TMH_ADDR_IRQ_STATUS, 1'b1, 8'h01);
    repeat (3) @(posedge hclk);
    chk(irq, 0);
    $display("interrupt done");
  endtask
  // ****
  // sequence and watchdog
  // ****
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_interval();
    t_clksel();
    t_pwm();
    t_irq();
    end_of_test();
  end
  // worst case is the 4096 prescale, about 16k cycles
  initial
  begin
    repeat (50000) @(posedge hclk);
    failures++;
    end_of_test();
  end
endmodule // tmh_timer_test
`default_nettype wire

//--- src/tmh_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tmh_timer
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // low-speed oscillator tick, one cycle per oscillator period
  input wire logic ls_osc_tick,
  // timer pin and interrupts
  output logic timer_out_pin,
  output logic match_irq,
  output logic irq
);
  import tmh_pkg::*;

  // ************************************************************
  // bus slave
  // ************************************************************
  logic wr_pend;
  logic [15:0] wr_addr;
  logic [7:0] period_compare;
  logic [7:0] duty_compare;
  logic [7:0] duty_active;
  logic duty_pend;
  tmh_mode_control_t mode_control;
  logic irq_status;
  logic irq_mask;
  logic [7:0] count;
  logic cmp_duty;
  logic out_active;
  logic match_evt;
  logic [7:0] next_rdata;
  logic addr_ok;

  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 16'h0000;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite;
      if (addr_ok)
        wr_addr <= haddr[17:2];
    end
  end

  always_comb
  begin
    case (haddr[17:2])
      TMH_ADDR_PERIOD: next_rdata = period_compare;
      TMH_ADDR_DUTY: next_rdata = duty_compare;
      TMH_ADDR_MODE: next_rdata = mode_control;
      TMH_ADDR_IRQ_STATUS: next_rdata = {7'h00, irq_status};
      TMH_ADDR_IRQ_MASK: next_rdata = {7'h00, irq_mask};
      default: next_rdata = 8'h00;
    endcase
  end

  // read data registered in the address phase: zero wait states
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite)
        hrdata <= {24'h000000, next_rdata};
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic wr_period;
  logic wr_duty;
  logic wr_mode;
  assign wr_period = wr_pend && (wr_addr == TMH_ADDR_PERIOD);
  assign wr_duty = wr_pend && (wr_addr == TMH_ADDR_DUTY);
  assign wr_mode = wr_pend && (wr_addr == TMH_ADDR_MODE);

  // whole-byte compare writes; a single-bit write lands as a byte write carrying the other bits back
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      period_compare <= TMH_RST_REG8;
      duty_compare <= TMH_RST_REG8;
      mode_control <= TMH_RST_REG8;
    end
    else
    begin
      if (wr_period)
        period_compare <= hwdata[7:0];
      if (wr_duty)
        duty_compare <= hwdata[7:0];
      if (wr_mode)
        mode_control <= hwdata[7:0];
    end
  end

  // ************************************************************
  // count clock prescaler
  // ************************************************************
  logic [TMH_PRE_W-1:0] pre;
  logic [TMH_LS_DIV_W-1:0] ls_div;
  logic cnt_tick;
  logic run;
  logic run_d;
  logic [TMH_PRE_W-1:0] next_pre;

  assign run = mode_control.run_enable;
  assign next_pre = pre + {{(TMH_PRE_W-1){1'b0}}, 1'b1};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre <= '0;
      ls_div <= '0;
      cnt_tick <= 1'b0;
    end
    else if (!run)
    begin
      pre <= '0;
      ls_div <= '0;
      cnt_tick <= 1'b0;
    end
    else
    begin
      pre <= next_pre;
      if (ls_osc_tick)
        ls_div <= ls_div + {{(TMH_LS_DIV_W-1){1'b0}}, 1'b1};
      case (mode_control.clk_sel)
        TMH_CKS_DIV1: cnt_tick <= 1'b1;
        TMH_CKS_DIV4: cnt_tick <= (next_pre[1:0] == 2'h0);
        TMH_CKS_DIV16: cnt_tick <= (next_pre[3:0] == 4'h0);
        TMH_CKS_DIV64: cnt_tick <= (next_pre[5:0] == 6'h00);
        TMH_CKS_DIV4096: cnt_tick <= (next_pre == '0);
        TMH_CKS_LSOSC128: cnt_tick <= ls_osc_tick && (ls_div == '1);
        default: cnt_tick <= 1'b0;
      endcase
    end
  end

  // ************************************************************
  // counter and compare
  // ************************************************************
  logic pwm;
  logic [7:0] cmp_val;
  logic hit;
  assign pwm = (mode_control.op_mode_sel == TMH_MODE_PWM);
  assign cmp_val = (pwm && cmp_duty) ? duty_active : period_compare;
  assign hit = cnt_tick && (count == cmp_val);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_d <= 1'b0;
      count <= 8'h00;
      cmp_duty <= 1'b0;
      out_active <= 1'b0;
      match_evt <= 1'b0;
    end
    else
    begin
      run_d <= run;
      match_evt <= 1'b0;
      if (!run)
      begin
        count <= 8'h00;
        cmp_duty <= 1'b0;
        out_active <= 1'b0;
      end
      else if (!run_d)
        count <= 8'h00;
      else if (hit && !(pwm && cmp_duty))
      begin
        count <= 8'h00;
        match_evt <= 1'b1;
        cmp_duty <= pwm;
        out_active <= pwm ? 1'b1 : ~out_active;
      end
      else if (hit)
      begin
        cmp_duty <= 1'b0;
        out_active <= 1'b0;
        count <= count + 8'h01;
      end
      else if (cnt_tick)
        count <= count + 8'h01;
    end
  end

  // duty shadow: loads on old-value duty match, write colliding with match waits one more
  logic duty_hit;
  assign duty_hit = pwm && cmp_duty && hit;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      duty_active <= TMH_RST_REG8;
      duty_pend <= 1'b0;
    end
    else if (!run)
    begin
      duty_active <= duty_compare;
      duty_pend <= 1'b0;
    end
    else if (wr_duty)
      duty_pend <= 1'b1;
    else if (duty_hit && duty_pend)
    begin
      duty_active <= duty_compare;
      duty_pend <= 1'b0;
    end
  end

  // ************************************************************
  // outputs and interrupt
  // ************************************************************
  logic clr_status;
  assign clr_status = wr_pend && (wr_addr == TMH_ADDR_IRQ_STATUS) && hwdata[0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timer_out_pin <= 1'b0;
      match_irq <= 1'b0;
      irq_status <= 1'b0;
      irq_mask <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      // level bit 1 means active-low output, matching the default-high idle
      timer_out_pin <= mode_control.out_gate ? (out_active ^ mode_control.out_default_level)
        : mode_control.out_default_level;
      match_irq <= match_evt && run;
      if (match_evt)
        irq_status <= 1'b1;
      else if (clr_status)
        irq_status <= 1'b0;
      if (wr_pend && (wr_addr == TMH_ADDR_IRQ_MASK))
        irq_mask <= hwdata[0];
      irq <= (irq_status || match_evt) && irq_mask;
    end
  end

endmodule // tmh_timer
`default_nettype wire
